// File: pkg/gpio_params.svh
// Constants for the GPIO port with front-end phase servo
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
// Register byte addresses
`define ADDR_DIR 8'h00
`define ADDR_OUT 8'h04
`define ADDR_IN 8'h08
`define ADDR_MODE 8'h0c
`define ADDR_FE_PH_SET 8'h10
`define ADDR_FE_ATT 8'h14
`define ADDR_BE_PH 8'h18
`define ADDR_BE_ATT 8'h1c
`define ADDR_SERVO_CTL 8'h20
`define ADDR_GAIN 8'h24
`define ADDR_IN_OFS 8'h28
`define ADDR_SAT_LIM 8'h2c
`define ADDR_FE_PH_RD 8'h30
`define ADDR_CORR_RD 8'h34
`define ADDR_CIC_RD 8'h38
// Field positions
`define MODE_FEBE_BIT 0
`define SERVO_CLOSE_BIT 0
`define SERVO_SIGN_BIT 1
`define GAIN_SHIFT 8
// Reset values
`define RST_WORD 32'h0000_0000
// Attenuator: 6-bit code in 0.5 dB steps, 63 = 31.5 dB
`define ATT_MAX_CODE 6'h3f
// Lines forced to outputs in front/back-end mode
`define FEBE_OUT_MASK 32'h00ff_ffff
// CIC decimation: 10^9 samples
`define CIC_DECIM 1000000000
`endif

// File: pkg/gpio_pkg.sv
// Types for the GPIO port with front-end phase servo
package gpio_pkg;
	typedef enum logic {MODE_BITWISE, MODE_FEBE} port_mode_t;
	typedef logic [11:0] phase_t;
	typedef logic [15:0] adc_t;
endpackage

// File: pkg/servo_if.sv
// Link between the port top and the phase servo
`timescale 1ns/1ns
`default_nettype none
interface servo_if;
	import gpio_pkg::*;
	logic close;
	logic sign;
	logic [4:0] gain_shift;
	adc_t in_ofs;
	phase_t sat_lim;
	adc_t adc;
	logic adc_vld;
	logic signed [12:0] corr;
	modport ctl(output close, sign, gain_shift, in_ofs, sat_lim, adc, adc_vld, input corr);
	modport srv(input close, sign, gain_shift, in_ofs, sat_lim, adc, adc_vld, output corr);
endinterface
`default_nettype wire

// File: hw/phase_servo.sv
// Phase servo integrator with symmetric clamp
`timescale 1ns/1ns
`default_nettype none
module phase_servo (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Control and result
	servo_if.srv sif
);
	import gpio_pkg::*;
	typedef struct packed {
		logic signed [31:0] acc;
	} srv_state_t;
	srv_state_t st_ff, nxt_st;
	logic signed [31:0] err, step, lim, cand;
	// Error, gain, sign, clamp
	always_comb begin
		err = 32'(signed'({1'b0, sif.adc})) - 32'(signed'({1'b0, sif.in_ofs}));
		step = err >>> sif.gain_shift;
		if (sif.sign)
			step = -step;
		lim = 32'(signed'({1'b0, sif.sat_lim})) <<< 16;
		cand = st_ff.acc + step;
		nxt_st = st_ff;
		if (!sif.close)
			nxt_st.acc = 32'sh0; // Open loop drops correction
		else if (sif.adc_vld) begin
			// Saturate and freeze integrator at the limit
			if (cand > lim)
				nxt_st.acc = lim;
			else if (cand < -lim)
				nxt_st.acc = -lim;
			else
				nxt_st.acc = cand;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	assign sif.corr = 13'(st_ff.acc >>> 16);
	property p_open_zero;
		@(posedge clk) disable iff (sys_rst) !sif.close |=> st_ff.acc == 0;
	endproperty
	a_open_zero: assert property (p_open_zero) else $error("open loop kept correction");
endmodule // phase_servo
`default_nettype wire

// File: hw/gpio_port.sv
// GPIO port with bit-wise and front/back-end personalities
//
// Overview of operation
// - 32 lines, each with its own direction and output value.
// - Each line readable; outputs read back the driven value.
// - Mode selector picks bit-wise or front/back-end personality.
// - Front/back-end mode forces a fixed set of lines to outputs.
// - Front-end phase register is readable.
// - Open loop: phase register equals setpoint.
// - Closed loop: phase register is setpoint plus servo correction, clamped to 0..0xfff.
// - Servo close control switches open/closed updating.
// - Attenuators in 0.5 dB steps, 0 to 31.5 dB, rounded.
// - Polarity control inverts the correction sign.
// - Error scaled by programmable gain.
// - Programmable input offset subtracted from ADC value.
// - Correction limited to programmable maximum deviation.
// - CIC decimator averages 10^9 ADC samples, output readable.
// - Present servo correction is readable.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_params.svh"
module gpio_port #(
	parameter int unsigned CIC_DECIM = `CIC_DECIM
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// ADC sample stream
	input wire gpio_pkg::adc_t adc_data,
	input wire logic adc_vld,
	// Pins
	input wire logic [31:0] pin_in,
	output logic [31:0] pin_out,
	output logic [31:0] pin_oe_n
);
	import gpio_pkg::*;

	// Refuse a decimation that the dump counter could never reach
	if (CIC_DECIM < 2) begin : g_bad_decim
		$error("CIC_DECIM too small");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] dir;
		logic [31:0] outv;
		port_mode_t mode;
		phase_t fe_set;
		logic [5:0] fe_att;
		phase_t be_ph;
		logic [5:0] be_att;
		logic close;
		logic sign;
		logic [4:0] gain;
		adc_t in_ofs;
		phase_t sat;
		phase_t fe_ph;
		logic [47:0] cic_acc;
		logic [31:0] cic_cnt;
		logic [31:0] cic_out;
		logic [31:0] rdata;
	} st_t;
	st_t st_ff, nxt_st;
	servo_if sif();

	// Rounds a value in 0.25 dB units to the nearest 0.5 dB code
	function automatic logic [5:0] att_round(input logic [31:0] q);
		logic [31:0] c;
		// Clamp before rounding so a huge request cannot wrap to zero
		if (q > 32'd125)
			return `ATT_MAX_CODE;
		c = (q + 32'h1) >> 1;
		return c[5:0];
	endfunction

	assign sif.close = st_ff.close;
	assign sif.sign = st_ff.sign;
	assign sif.gain_shift = st_ff.gain;
	assign sif.in_ofs = st_ff.in_ofs;
	assign sif.sat_lim = st_ff.sat;
	assign sif.adc = adc_data;
	assign sif.adc_vld = adc_vld;

	phase_servo u_servo (
		.clk(clk),
		.sys_rst(sys_rst),
		.sif(sif)
	);

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	logic [31:0] oe;
	logic [31:0] febe_pins;
	always_comb begin
		febe_pins = {8'h00, st_ff.be_att[5:0], st_ff.fe_att[5:0], st_ff.fe_ph};
		oe = st_ff.dir;
		if (st_ff.mode == MODE_FEBE)
			oe = st_ff.dir | `FEBE_OUT_MASK;
	end
	assign pin_out = (st_ff.mode == MODE_FEBE) ?
		((febe_pins & `FEBE_OUT_MASK) | (st_ff.outv & ~`FEBE_OUT_MASK)) : st_ff.outv;
	assign pin_oe_n = ~oe;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic [31:0] lvl;
	logic signed [13:0] sum;
	always_comb begin
		nxt_st = st_ff;
		lvl = (oe & pin_out) | (~oe & pin_in);
		// Phase register: setpoint plus correction when closed, clamped to 0..0xfff
		sum = 14'(signed'({2'b00, st_ff.fe_set})) + 14'(sif.corr);
		if (!st_ff.close)
			nxt_st.fe_ph = st_ff.fe_set;
		else if (sum < 0)
			nxt_st.fe_ph = '0;
		else if (sum > 14'sh0fff)
			nxt_st.fe_ph = 12'hfff;
		else
			nxt_st.fe_ph = sum[11:0];
		// CIC decimator, first order integrate and dump
		if (adc_vld) begin
			if (st_ff.cic_cnt == CIC_DECIM - 1) begin
				nxt_st.cic_out = 32'((st_ff.cic_acc + 48'(adc_data)) / 48'(CIC_DECIM));
				nxt_st.cic_acc = '0;
				nxt_st.cic_cnt = '0;
			end else begin
				nxt_st.cic_acc = st_ff.cic_acc + 48'(adc_data);
				nxt_st.cic_cnt = st_ff.cic_cnt + 32'h1;
			end
		end
		// Register writes
		if (wr) begin
			case (addr)
				`ADDR_DIR: nxt_st.dir = wdata;
				`ADDR_OUT: nxt_st.outv = wdata;
				`ADDR_MODE: nxt_st.mode = port_mode_t'(wdata[`MODE_FEBE_BIT]);
				`ADDR_FE_PH_SET: nxt_st.fe_set = wdata[11:0];
				`ADDR_FE_ATT: nxt_st.fe_att = att_round(wdata);
				`ADDR_BE_PH: nxt_st.be_ph = wdata[11:0];
				`ADDR_BE_ATT: nxt_st.be_att = att_round(wdata);
				`ADDR_SERVO_CTL: begin
					nxt_st.close = wdata[`SERVO_CLOSE_BIT];
					nxt_st.sign = wdata[`SERVO_SIGN_BIT];
				end
				`ADDR_GAIN: nxt_st.gain = wdata[4:0];
				`ADDR_IN_OFS: nxt_st.in_ofs = wdata[15:0];
				`ADDR_SAT_LIM: nxt_st.sat = wdata[11:0];
				default: ;
			endcase
		end
		// Read data for the cycle after the strobe
		nxt_st.rdata = 32'h0;
		if (rd) begin
			case (addr)
				`ADDR_DIR: nxt_st.rdata = st_ff.dir;
				`ADDR_OUT: nxt_st.rdata = st_ff.outv;
				`ADDR_IN: nxt_st.rdata = lvl;
				`ADDR_MODE: nxt_st.rdata = {31'h0, st_ff.mode};
				`ADDR_FE_PH_SET: nxt_st.rdata = {20'h0, st_ff.fe_set};
				`ADDR_FE_ATT: nxt_st.rdata = {26'h0, st_ff.fe_att};
				`ADDR_BE_PH: nxt_st.rdata = {20'h0, st_ff.be_ph};
				`ADDR_BE_ATT: nxt_st.rdata = {26'h0, st_ff.be_att};
				`ADDR_SERVO_CTL: nxt_st.rdata = {30'h0, st_ff.sign, st_ff.close};
				`ADDR_GAIN: nxt_st.rdata = {27'h0, st_ff.gain};
				`ADDR_IN_OFS: nxt_st.rdata = {16'h0, st_ff.in_ofs};
				`ADDR_SAT_LIM: nxt_st.rdata = {20'h0, st_ff.sat};
				`ADDR_FE_PH_RD: nxt_st.rdata = {20'h0, st_ff.fe_ph};
				`ADDR_CORR_RD: nxt_st.rdata = 32'(sif.corr);
				`ADDR_CIC_RD: nxt_st.rdata = st_ff.cic_out;
				default: nxt_st.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	assign rdata = st_ff.rdata;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Signed copy of the limit so the clamp checks compare like with like
	logic signed [12:0] sat_s;
	assign sat_s = signed'({1'b0, st_ff.sat});

	// Pin personality, open-loop phase, attenuator, clamp and read-slot checks
	property p_oe_dir;
		@(posedge clk) disable iff (sys_rst) st_ff.mode == MODE_BITWISE |-> pin_oe_n == ~st_ff.dir;
	endproperty
	a_oe_dir: assert property (p_oe_dir) else $error("bitwise oe wrong");
	property p_readback;
		@(posedge clk) disable iff (sys_rst)
			rd && addr == `ADDR_IN |=> rdata == ($past(pin_out) & ~$past(pin_oe_n) | $past(pin_in) & $past(pin_oe_n));
	endproperty
	a_readback: assert property (p_readback) else $error("readback wrong");
	property p_force;
		@(posedge clk) disable iff (sys_rst) st_ff.mode == MODE_FEBE |-> (~pin_oe_n & `FEBE_OUT_MASK) == `FEBE_OUT_MASK;
	endproperty
	a_force: assert property (p_force) else $error("febe lines not output");
	property p_open;
		@(posedge clk) disable iff (sys_rst) !st_ff.close ##1 !st_ff.close |-> st_ff.fe_ph == $past(st_ff.fe_set);
	endproperty
	a_open: assert property (p_open) else $error("open loop phase wrong");
	property p_att;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_FE_ATT && wdata == 32'h6
			|=> st_ff.fe_att == 6'h3;
	endproperty
	a_att: assert property (p_att) else $error("attenuator rounding wrong");
	property p_att_max;
		@(posedge clk) disable iff (sys_rst) st_ff.fe_att <= `ATT_MAX_CODE && st_ff.be_att <= `ATT_MAX_CODE;
	endproperty
	a_att_max: assert property (p_att_max) else $error("attenuator range");
	property p_clamp;
		@(posedge clk) disable iff (sys_rst) sif.corr <= sat_s && sif.corr >= -sat_s;
	endproperty
	a_clamp: assert property (p_clamp) else $error("correction exceeds limit");
	property p_rd_zero;
		@(posedge clk) disable iff (sys_rst) !rd |=> rdata == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");

	// Personality outputs
	property p_febe_pins;
		@(posedge clk) disable iff (sys_rst) st_ff.mode == MODE_FEBE
			|-> pin_out[23:0] == {st_ff.be_att, st_ff.fe_att, st_ff.fe_ph};
	endproperty
	a_febe_pins: assert property (p_febe_pins) else $error("febe pin content wrong");
	property p_upper_dir;
		@(posedge clk) disable iff (sys_rst) st_ff.mode == MODE_FEBE
			|-> pin_oe_n[31:24] == ~st_ff.dir[31:24];
	endproperty
	a_upper_dir: assert property (p_upper_dir) else $error("upper lines lost dir");
	property p_out_bitwise;
		@(posedge clk) disable iff (sys_rst) st_ff.mode == MODE_BITWISE |-> pin_out == st_ff.outv;
	endproperty
	a_out_bitwise: assert property (p_out_bitwise) else $error("bitwise out wrong");

	// Register writes land one cycle after the strobe
	property p_dir_wr;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_DIR |=> st_ff.dir == $past(wdata);
	endproperty
	a_dir_wr: assert property (p_dir_wr) else $error("dir write lost");
	property p_out_wr;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_OUT |=> st_ff.outv == $past(wdata);
	endproperty
	a_out_wr: assert property (p_out_wr) else $error("out write lost");
	property p_mode_wr;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_MODE
			|=> st_ff.mode == port_mode_t'($past(wdata[`MODE_FEBE_BIT]));
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
	property p_set_wr;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_FE_PH_SET
			|=> st_ff.fe_set == $past(wdata[11:0]);
	endproperty
	a_set_wr: assert property (p_set_wr) else $error("setpoint write lost");
	property p_be_ph_wr;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_BE_PH
			|=> st_ff.be_ph == $past(wdata[11:0]);
	endproperty
	a_be_ph_wr: assert property (p_be_ph_wr) else $error("back-end phase write lost");
	property p_att_clamp;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_BE_ATT && wdata == 32'd200
			|=> st_ff.be_att == `ATT_MAX_CODE;
	endproperty
	a_att_clamp: assert property (p_att_clamp) else $error("attenuator clamp wrong");
	property p_close_wr;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_SERVO_CTL
			|=> st_ff.close == $past(wdata[`SERVO_CLOSE_BIT]);
	endproperty
	a_close_wr: assert property (p_close_wr) else $error("close control lost");
	property p_sign_wr;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_SERVO_CTL
			|=> st_ff.sign == $past(wdata[`SERVO_SIGN_BIT]);
	endproperty
	a_sign_wr: assert property (p_sign_wr) else $error("sign control lost");
	property p_gain_wr;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_GAIN
			|=> st_ff.gain == $past(wdata[4:0]);
	endproperty
	a_gain_wr: assert property (p_gain_wr) else $error("gain write lost");
	property p_ofs_wr;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_IN_OFS
			|=> st_ff.in_ofs == $past(wdata[15:0]);
	endproperty
	a_ofs_wr: assert property (p_ofs_wr) else $error("offset write lost");
	property p_sat_wr;
		@(posedge clk) disable iff (sys_rst) wr && addr == `ADDR_SAT_LIM
			|=> st_ff.sat == $past(wdata[11:0]);
	endproperty
	a_sat_wr: assert property (p_sat_wr) else $error("limit write lost");

	// Readouts stand only in the cycle after the read strobe
	property p_fe_rd;
		@(posedge clk) disable iff (sys_rst) rd && addr == `ADDR_FE_PH_RD
			|=> rdata == {20'h0, $past(st_ff.fe_ph)};
	endproperty
	a_fe_rd: assert property (p_fe_rd) else $error("phase readout wrong");
	property p_corr_rd;
		@(posedge clk) disable iff (sys_rst) rd && addr == `ADDR_CORR_RD
			|=> rdata == 32'($past(sif.corr));
	endproperty
	a_corr_rd: assert property (p_corr_rd) else $error("correction readout wrong");
	property p_cic_rd;
		@(posedge clk) disable iff (sys_rst) rd && addr == `ADDR_CIC_RD
			|=> rdata == $past(st_ff.cic_out);
	endproperty
	a_cic_rd: assert property (p_cic_rd) else $error("decimator readout wrong");
	property p_unmapped;
		@(posedge clk) disable iff (sys_rst) rd && addr == 8'h3c |=> rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	// Servo and phase register behaviour
	property p_open_corr;
		@(posedge clk) disable iff (sys_rst) !st_ff.close |=> sif.corr == 13'sh0;
	endproperty
	a_open_corr: assert property (p_open_corr) else $error("open loop correction");
	property p_closed;
		@(posedge clk) disable iff (sys_rst) st_ff.close && sum >= 0 && sum <= 14'sh0fff
			|=> st_ff.fe_ph == $past(sum[11:0]);
	endproperty
	a_closed: assert property (p_closed) else $error("closed loop phase wrong");
	property p_sum_low;
		@(posedge clk) disable iff (sys_rst) st_ff.close && sum < 0 |=> st_ff.fe_ph == 12'h000;
	endproperty
	a_sum_low: assert property (p_sum_low) else $error("phase underflow");
	property p_sum_high;
		@(posedge clk) disable iff (sys_rst) st_ff.close && sum > 14'sh0fff
			|=> st_ff.fe_ph == 12'hfff;
	endproperty
	a_sum_high: assert property (p_sum_high) else $error("phase overflow");
	// The average only moves when a sample arrives
	property p_cic_hold;
		@(posedge clk) disable iff (sys_rst) !adc_vld |=> $stable(st_ff.cic_out);
	endproperty
	a_cic_hold: assert property (p_cic_hold) else $error("average moved without sample");

	// Main scenarios
	c_febe: cover property (@(posedge clk) st_ff.mode == MODE_FEBE && st_ff.close);
	c_neg: cover property (@(posedge clk) st_ff.close && st_ff.sign && sif.corr < 0);
	c_clamp: cover property (@(posedge clk) st_ff.close && sif.corr == 13'(st_ff.sat) && st_ff.sat != 0);
	c_cic: cover property (@(posedge clk) adc_vld && st_ff.cic_cnt == CIC_DECIM - 1);
endmodule // gpio_port
`default_nettype wire

// File: bench/febe_model.sv
// External front/back-end phase shifter and attenuator hardware model
`timescale 1ns/1ns
`default_nettype none
module febe_model (
	// Clock
	input wire logic clk,
	// Port pins and what the outside world drives
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe_n,
	input wire logic [31:0] ext_drive,
	// Resolved pin levels and latched settings
	output logic [31:0] pin_level,
	output logic [11:0] fe_phase,
	output logic [5:0] fe_att,
	output logic [5:0] be_att
);
	wire logic all_drv;
	// Released lines show the external level, driven lines the port value
	assign pin_level = (pin_out & ~pin_oe_n) | (ext_drive & pin_oe_n);
	assign all_drv = (pin_oe_n[23:0] == 24'h0);
	// Settings latch only while the port owns the lines; otherwise they scramble
	always_ff @(posedge clk) begin
		if (all_drv) begin
			{be_att, fe_att, fe_phase} <= pin_out[23:0];
		end else begin
			{be_att, fe_att, fe_phase} <= ~{be_att, fe_att, fe_phase};
		end
	end
endmodule // febe_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the GPIO port with phase servo
`timescale 1ns/1ns
`default_nettype none
`include "gpio_params.svh"
module tb;
	import gpio_pkg::*;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic clk, sys_rst, wr, rd, adc_vld;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, pin_in, pin_out, pin_oe_n, lvl;
	adc_t adc_data;
	logic [11:0] m_ph;
	logic [5:0] m_fa, m_ba;
	logic [31:0] r;
	int fails, checked, cyc;
	gpio_port #(.CIC_DECIM(4)) DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .adc_data(adc_data),
		.adc_vld(adc_vld), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
	febe_model model (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.ext_drive(32'h5a5a_c3c3), .pin_level(lvl), .fe_phase(m_ph), .fe_att(m_fa),
		.be_att(m_ba));
	assign pin_in = lvl;
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
		@(posedge clk) wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk) begin addr <= a; rd <= 1'b1; end
		@(posedge clk) rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Stream n samples of one value, then let the phase register settle
	task automatic run(input int n, input adc_t a);
		@(posedge clk) begin adc_data <= a; adc_vld <= 1'b1; end
		repeat (n) @(posedge clk);
		adc_vld <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk("oe_n", pin_oe_n, 32'hffff_ffff);
		rd_reg(`ADDR_MODE, r); chk("mode", r, 32'h0);
		rd_reg(`ADDR_CORR_RD, r); chk("corr", r, 32'h0);
		rd_reg(8'h3c, r); chk("unmapped", r, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_bitwise;
		wr_reg(`ADDR_DIR, 32'hffff_0000);
		wr_reg(`ADDR_OUT, 32'h1234_5678);
		@(posedge clk) #1 chk("oe_n", pin_oe_n, 32'h0000_ffff);
		chk("out", pin_out & 32'hffff_0000, 32'h1234_0000);
		rd_reg(`ADDR_IN, r); chk("level", r, 32'h1234_c3c3);
		wr_reg(`ADDR_DIR, 32'h0);
		$display("test bitwise done");
	endtask
	task automatic t_febe;
		wr_reg(`ADDR_FE_PH_SET, 32'h0000_0abc);
		wr_reg(`ADDR_FE_ATT, 32'd6);
		wr_reg(`ADDR_BE_ATT, 32'd200);
		wr_reg(`ADDR_MODE, 32'h1);
		repeat (2) @(posedge clk);
		#1 chk("oe_n", pin_oe_n, 32'hff00_0000);
		chk("pins", pin_out[23:0], 24'hfc3abc);
		chk("model", {m_ba, m_fa, m_ph}, 24'hfc3abc);
		rd_reg(`ADDR_FE_PH_RD, r); chk("fe_phase", r, 32'h0abc);
		$display("test febe done");
	endtask
	task automatic t_servo;
		wr_reg(`ADDR_FE_PH_SET, 32'h0000_0800);
		wr_reg(`ADDR_SAT_LIM, 32'h3);
		wr_reg(`ADDR_IN_OFS, 32'h4000);
		wr_reg(`ADDR_SERVO_CTL, 32'h1);
		run(40, 16'h4000);
		rd_reg(`ADDR_CORR_RD, r); chk("ofs corr", r, 32'h0);
		wr_reg(`ADDR_IN_OFS, 32'h0);
		wr_reg(`ADDR_GAIN, 32'h4);
		run(20, 16'h4000);
		rd_reg(`ADDR_CORR_RD, r); chk("gain corr", r, 32'h0);
		wr_reg(`ADDR_GAIN, 32'h0);
		run(40, 16'h4000);
		rd_reg(`ADDR_CORR_RD, r); chk("corr max", r[12:0], 13'h0003);
		rd_reg(`ADDR_FE_PH_RD, r); chk("ph max", r, 32'h0803);
		wr_reg(`ADDR_SERVO_CTL, 32'h3);
		run(32, 16'h4000);
		rd_reg(`ADDR_CORR_RD, r); chk("corr min", r[12:0], 13'h1ffd);
		rd_reg(`ADDR_FE_PH_RD, r); chk("ph min", r, 32'h07fd);
		chk("pin ph", pin_out[11:0], 12'h7fd);
		wr_reg(`ADDR_SERVO_CTL, 32'h0);
		repeat (2) @(posedge clk);
		rd_reg(`ADDR_FE_PH_RD, r); chk("ph open", r, 32'h0800);
		$display("test servo done");
	endtask
	task automatic t_cic;
		run(12, 16'h1234);
		rd_reg(`ADDR_CIC_RD, r); chk("cic", r, 32'h1234);
		$display("test cic done");
	endtask
	// ----------------------------------------
	// Clock, reset, sequence and timeout
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		fails = 0;
		checked = 0;
		{sys_rst, wr, rd, adc_vld, addr, wdata, adc_data} = '0;
		sys_rst = 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		#1 t_reset;
		t_bitwise;
		t_febe;
		t_servo;
		t_cic;
		summarize;
	end
	// Bench cycle ceiling well above the few hundred cycles the tests need
	initial begin
		for (cyc = 0; cyc < 5000; cyc++) @(posedge clk);
		fails++;
		summarize;
	end
endmodule // tb
`default_nettype wire
